// File: core/iitr_alu.sv
// incrementer with zero detection for the increment instructions
module iitr_alu #(
    parameter int WIDTH = 8
) (
    // operand
    input  wire logic [WIDTH-1:0] val_i,
    // result
    output logic      [WIDTH-1:0] sum_o,
    output logic                  zero_o
);
    if (WIDTH < 1) begin : g_width_chk
        $error("iitr_alu: width must be positive");
    end

    always_comb begin
        sum_o  = val_i + WIDTH'(1);
        zero_o = (sum_o == '0); // zero only after a wrap from all ones
    end
endmodule

// File: core/iitr_exec.sv
// execution unit for increment, increment-and-test and table read
module iitr_exec (
    // clock and reset
    input  wire logic                               ref_clk_i,
    input  wire logic                               arst_n_i,
    // instruction issue from the sequencer
    input  wire logic                               issue_i,
    input  wire logic [iitr_pkg::OPC_W-1:0]         opcode_i,
    output logic                                    busy_o,
    output logic                                    done_o,
    output logic                                    skip_next_o,
    // register file read of the operand
    output logic      [iitr_pkg::FADDR_W-1:0]       file_rd_addr_o,
    input  wire logic [iitr_pkg::DATA_W-1:0]        file_rd_data_i,
    // register file write back
    output iitr_pkg::iitr_fwr_type                  file_wr_o,
    // zero flag
    input  wire logic                               zero_i,
    output logic                                    zero_we_o,
    output logic                                    zero_o,
    // working and upper-address registers
    output logic      [iitr_pkg::DATA_W-1:0]        work_o,
    output logic      [iitr_pkg::DATA_W-1:0]        upper_addr_o,
    // program memory read port, data valid one cycle after request
    output logic                                    pmem_rd_o,
    output logic      [iitr_pkg::PADDR_W-1:0]       pmem_addr_o,
    input  wire logic [iitr_pkg::OPC_W-1:0]         pmem_data_i
);
    iitr_pkg::iitr_regs_type q, d;

    logic [iitr_pkg::DATA_W-1:0] inc_val;
    logic                        inc_zero;
    logic                        is_inc;
    logic                        is_incsz;
    logic                        is_iread;

    //**************************************************************************
    // decode
    //**************************************************************************
    always_comb begin
        is_inc   = opcode_i[11:iitr_pkg::OPC_SEL_LSB] == iitr_pkg::OPC_INC;   // see RL1
        is_incsz = opcode_i[11:iitr_pkg::OPC_SEL_LSB] == iitr_pkg::OPC_INCSZ; // see RL3
        is_iread = opcode_i == iitr_pkg::OPC_IREAD;                           // see RL6
    end

    assign file_rd_addr_o = opcode_i[iitr_pkg::FADDR_W-1:0];

    iitr_alu #(
        .WIDTH (iitr_pkg::DATA_W)
    ) u_alu (
        .val_i  (file_rd_data_i),
        .sum_o  (inc_val),
        .zero_o (inc_zero)
    );

    //**************************************************************************
    // next state
    //**************************************************************************
    always_comb begin
        d          = q;
        d.done     = 1'b0;
        d.skip     = 1'b0;
        d.fwr.we   = 1'b0;
        d.zero_we  = 1'b0;
        unique case (q.st)
            iitr_pkg::IITR_IDLE: begin
                if (issue_i && is_inc) begin
                    d.fwr.we   = 1'b1;                    // see RL1
                    d.fwr.addr = opcode_i[iitr_pkg::FADDR_W-1:0];
                    d.fwr.data = inc_val;
                    d.zero     = inc_zero;                // see RL2
                    d.zero_we  = 1'b1;
                    d.done     = 1'b1;
                end else if (issue_i && is_incsz) begin
                    // zero flag untouched; no write strobe to it
                    d.fwr.we   = 1'b1;                    // see RL3
                    d.fwr.addr = opcode_i[iitr_pkg::FADDR_W-1:0];
                    d.fwr.data = inc_val;
                    if (inc_zero) begin
                        d.st = iitr_pkg::IITR_SKIP;       // see RL4
                    end else begin
                        d.done = 1'b1;                    // see RL5
                    end
                end else if (issue_i && is_iread) begin
                    // address latched now so the overwrite cannot disturb it
                    d.paddr = {q.ua[iitr_pkg::NIB_W-1:0], q.w}; // see RL7 RL11
                    d.st    = iitr_pkg::IITR_RD_WAIT;
                end
            end
            iitr_pkg::IITR_SKIP: begin
                // the spare cycle stands in for the discarded instruction
                d.skip = 1'b1;                            // see RL10
                d.done = 1'b1;                            // see RL5
                d.st   = iitr_pkg::IITR_IDLE;
            end
            iitr_pkg::IITR_RD_WAIT: begin
                d.st = iitr_pkg::IITR_RD_DONE;
            end
            iitr_pkg::IITR_RD_DONE: begin
                d.ua   = {{(iitr_pkg::DATA_W-iitr_pkg::NIB_W){1'b0}},
                          pmem_data_i[11:8]};             // see RL8 RL9
                d.w    = pmem_data_i[7:0];                // see RL8
                d.done = 1'b1;                            // see RL6
                d.st   = iitr_pkg::IITR_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            q.st       <= iitr_pkg::IITR_IDLE;
            q.w        <= iitr_pkg::W_RST;
            q.ua       <= iitr_pkg::UA_RST;
            q.paddr    <= '0;
            q.zero     <= 1'b0;
            q.done     <= 1'b0;
            q.skip     <= 1'b0;
            q.fwr      <= '0;
            q.zero_we  <= 1'b0;
        end else begin
            q          <= d;
        end
    end

    //**************************************************************************
    // outputs
    //**************************************************************************
    assign busy_o       = q.st != iitr_pkg::IITR_IDLE;
    assign done_o       = q.done;
    assign skip_next_o  = q.skip;
    assign file_wr_o    = q.fwr;
    assign zero_we_o    = q.zero_we;
    // between writes the caller's flag is echoed so nothing changes
    assign zero_o       = q.zero_we ? q.zero : zero_i;
    assign work_o       = q.w;
    assign upper_addr_o = q.ua;
    assign pmem_rd_o    = q.st == iitr_pkg::IITR_RD_WAIT;
    assign pmem_addr_o  = q.paddr;
endmodule

// File: core/iitr_pkg.sv
// package of constants and carrier types for the increment and table read execution block
//******************************************************************************
// Overview of operation
// RL1 - increment opcode writes register plus one
// RL2 - increment sets zero on wrap, else clears
// RL3 - increment-and-test writes plus one, flags untouched
// RL4 - increment-and-test skips next when result zero
// RL5 - increment-and-test takes one or two cycles
// RL6 - table read opcode, three cycles, no flags
// RL7 - address is upper-address low nibble plus working
// RL8 - fetched word splits into upper-address and working
// RL9 - upper nibble of upper-address cleared after read
// RL10 - skipped instruction has no effects at all
// RL11 - address uses register values from instruction start
//******************************************************************************
package iitr_pkg;
    localparam int          OPC_W        = 12;
    localparam int          DATA_W       = 8;
    localparam int          FADDR_W      = 5;
    localparam int          PADDR_W      = 12;
    localparam int          NIB_W        = 4;
    // opcode patterns; for the increments top seven bits select, low five carry the operand; table read is matched whole
    localparam logic [6:0]  OPC_INC      = 7'h15;
    localparam logic [6:0]  OPC_INCSZ    = 7'h1f;
    localparam logic [11:0] OPC_IREAD    = 12'h041;
    localparam int          OPC_SEL_LSB  = 5;
    localparam int          CYC_INC      = 1;
    localparam int          CYC_INCSZ    = 1;
    localparam int          CYC_SKIP     = 2;
    localparam int          CYC_IREAD    = 3;
    localparam logic [7:0]  W_RST        = 8'h00;
    localparam logic [7:0]  UA_RST       = 8'h00;

    typedef enum logic [1:0] {
        IITR_IDLE,
        IITR_SKIP,
        IITR_RD_WAIT,
        IITR_RD_DONE
    } iitr_state_type;

    typedef struct packed {
        logic                 we;
        logic [FADDR_W-1:0]   addr;
        logic [DATA_W-1:0]    data;
    } iitr_fwr_type;

    typedef struct packed {
        iitr_state_type       st;
        logic [DATA_W-1:0]    w;
        logic [DATA_W-1:0]    ua;
        logic [PADDR_W-1:0]   paddr;
        logic                 zero;
        logic                 done;
        logic                 skip;
        logic                 zero_we;
        iitr_fwr_type         fwr;
    } iitr_regs_type;
endpackage

// File: verification/iitr_exec_bench.sv
// self-checking bench for the increment and table read execution block
module iitr_exec_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        ref_clk_i = 1'h0, arst_n_i = 1'h0, issue_i = 1'h0, zero_i = 1'h0;
    logic [11:0] opcode_i = 12'h000;
    logic        busy_o, done_o, skip_next_o, zero_we_o, zero_o, pmem_rd_o;
    logic [4:0]  file_rd_addr_o;
    logic [7:0]  file_rd_data_i, work_o, upper_addr_o;
    logic [11:0] pmem_addr_o, pmem_data_i;
    iitr_pkg::iitr_fwr_type file_wr_o;
    int          err_total = 0, comparisons = 0, cyc = 0;
    logic [31:0] rnd = 32'h723a;
    iitr_exec i_iitr_exec (
        .ref_clk_i      (ref_clk_i),
        .arst_n_i       (arst_n_i),
        .issue_i        (issue_i),
        .opcode_i       (opcode_i),
        .busy_o         (busy_o),
        .done_o         (done_o),
        .skip_next_o    (skip_next_o),
        .file_rd_addr_o (file_rd_addr_o),
        .file_rd_data_i (file_rd_data_i),
        .file_wr_o      (file_wr_o),
        .zero_i         (zero_i),
        .zero_we_o      (zero_we_o),
        .zero_o         (zero_o),
        .work_o         (work_o),
        .upper_addr_o   (upper_addr_o),
        .pmem_rd_o      (pmem_rd_o),
        .pmem_addr_o    (pmem_addr_o),
        .pmem_data_i    (pmem_data_i)
    );
    iitr_partner i_iitr_partner (.ref_clk_i(ref_clk_i), .rd_addr_i(file_rd_addr_o),
        .rd_data_o(file_rd_data_i), .wr_i(file_wr_o), .pmem_rd_i(pmem_rd_o),
        .pmem_addr_i(pmem_addr_o), .pmem_data_o(pmem_data_i));
    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [11:0] word_at(logic [11:0] a);
        return {a[3:0], a[11:4]} ^ 12'h5a3;
    endfunction
    task automatic chk(logic [11:0] got, logic [11:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("errors %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // hold keeps the strobe up so a following issue does not drop and raise it in one step
    task automatic issue(logic [11:0] op, logic hold = 1'h0);
        issue_i = 1'h1;
        opcode_i = op;
        @(negedge ref_clk_i);
        if (!hold) issue_i = 1'h0;
    endtask
    initial begin
        forever #10 ref_clk_i = ~ref_clk_i;
    end
    // a hang is cut short well past the hundred or so cycles the run needs
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            err_total++;
            wrap_up();
        end
    end
    initial begin
        logic [7:0]  v;
        logic [4:0]  a;
        logic [11:0] ad;
        repeat (4) @(negedge ref_clk_i);
        arst_n_i = 1'h1;
        @(negedge ref_clk_i);
        for (int i = 0; i < 40; i++) begin
            rnd = lfsr(rnd);
            a = rnd[4:0];
            v = (i < 2) ? 8'hff : rnd[12:5];
            zero_i = rnd[13];
            i_iitr_partner.regs[a] = v;
            issue({i[0] ? iitr_pkg::OPC_INCSZ : iitr_pkg::OPC_INC, a});
            chk(file_rd_addr_o, a);
            chk(zero_we_o, !i[0]);
            chk(zero_o, i[0] ? zero_i : v == 8'hff);
            chk(done_o, !i[0] || v != 8'hff);
            @(negedge ref_clk_i);
            chk(i_iitr_partner.regs[a], 8'(v + 8'h01));
            chk(skip_next_o, i[0] && v == 8'hff);
            chk(done_o, i[0] && v == 8'hff);
            chk(file_wr_o.we | zero_we_o, 1'h0);
        end
        issue(12'hfff);
        chk(done_o | file_wr_o.we, 1'h0);
        i_iitr_partner.regs[0] = 8'h33;
        ad = 12'h000;
        for (int k = 0; k < 6; k++) begin
            issue(iitr_pkg::OPC_IREAD, 1'h1);
            chk(pmem_addr_o, ad);
            issue({iitr_pkg::OPC_INC, 5'h00});
            ad = word_at(ad);
            @(negedge ref_clk_i);
            chk(done_o, 1'h1);
            chk({upper_addr_o[3:0], work_o}, ad);
            chk(upper_addr_o[7:4], 4'h0);
        end
        chk(i_iitr_partner.regs[0], 8'h33);
        wrap_up();
    end
endmodule

// File: verification/iitr_partner.sv
// register file and program memory port model around the execution block
module iitr_partner (
    input  wire logic                   ref_clk_i,
    input  wire logic [4:0]             rd_addr_i,
    output logic      [7:0]             rd_data_o,
    input  wire iitr_pkg::iitr_fwr_type wr_i,
    input  wire logic                   pmem_rd_i,
    input  wire logic [11:0]            pmem_addr_i,
    output logic      [11:0]            pmem_data_o = 12'h000
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] regs [32] = '{default: 8'h00};
    assign rd_data_o = regs[rd_addr_i];
    always @(posedge ref_clk_i) begin
        if (wr_i.we) begin
            regs[wr_i.addr] <= wr_i.data;
        end
        // the word is valid only after a request; otherwise it toggles so stale data never matches
        pmem_data_o <= pmem_rd_i ? {pmem_addr_i[3:0], pmem_addr_i[11:4]} ^ 12'h5a3 : ~pmem_data_o;
    end
endmodule

// File: verification/iitr_properties.sv
// concurrent checks on the execution block ports
module iitr_properties (
    input wire logic                   ref_clk_i,
    input wire logic                   arst_n_i,
    input wire logic                   issue_i,
    input wire logic [11:0]            opcode_i,
    input wire logic                   busy_o,
    input wire logic                   done_o,
    input wire logic                   skip_next_o,
    input wire logic [7:0]             file_rd_data_i,
    input wire iitr_pkg::iitr_fwr_type file_wr_o,
    input wire logic                   zero_we_o,
    input wire logic                   zero_o,
    input wire logic [7:0]             work_o,
    input wire logic [7:0]             upper_addr_o,
    input wire logic                   pmem_rd_o,
    input wire logic [11:0]            pmem_addr_o,
    input wire logic [11:0]            pmem_data_i
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);
    logic ti, ts, tr;
    assign ti = issue_i && !busy_o && opcode_i[11:5] == iitr_pkg::OPC_INC;
    assign ts = issue_i && !busy_o && opcode_i[11:5] == iitr_pkg::OPC_INCSZ;
    assign tr = issue_i && !busy_o && opcode_i == iitr_pkg::OPC_IREAD;
    sequence rd_req;
        pmem_rd_o && busy_o;
    endsequence
    sequence rd_fin;
        busy_o ##1 done_o;
    endsequence
    inc_write_a: assert property (
        ti |=> done_o && file_wr_o.we && file_wr_o.addr == $past(opcode_i[4:0])
            && file_wr_o.data == $past(file_rd_data_i) + 8'h01)
        else $error("inc write");
    inc_zero_a: assert property (
        ti |=> zero_we_o && zero_o == ($past(file_rd_data_i) == 8'hff))
        else $error("inc zero");
    incsz_flags_a: assert property (
        ts |=> !zero_we_o && file_wr_o.we && file_wr_o.data == $past(file_rd_data_i) + 8'h01)
        else $error("incsz flags");
    skip_zero_a: assert property (
        ts && file_rd_data_i == 8'hff |=> !done_o ##1 done_o && skip_next_o)
        else $error("skip zero");
    no_skip_a: assert property (
        ts && file_rd_data_i != 8'hff |=> done_o && !skip_next_o && !busy_o)
        else $error("no skip");
    skip_quiet_a: assert property (
        skip_next_o |-> done_o && !file_wr_o.we && !zero_we_o)
        else $error("skip quiet");
    read_addr_a: assert property (
        tr |=> rd_req ##0 pmem_addr_o == {$past(upper_addr_o[3:0]), $past(work_o)})
        else $error("read addr");
    read_time_a: assert property (
        tr |=> rd_req ##1 rd_fin)
        else $error("read time");
    read_flags_a: assert property (
        tr |=> (!zero_we_o) [*3])
        else $error("read flags");
    read_load_a: assert property (
        tr ##2 1'b1 |=> work_o == $past(pmem_data_i[7:0])
            && upper_addr_o == {4'h0, $past(pmem_data_i[11:8])})
        else $error("read load");
endmodule
bind iitr_exec iitr_properties i_iitr_properties (
    .ref_clk_i      (ref_clk_i),
    .arst_n_i       (arst_n_i),
    .issue_i        (issue_i),
    .opcode_i       (opcode_i),
    .busy_o         (busy_o),
    .done_o         (done_o),
    .skip_next_o    (skip_next_o),
    .file_rd_data_i (file_rd_data_i),
    .file_wr_o      (file_wr_o),
    .zero_we_o      (zero_we_o),
    .zero_o         (zero_o),
    .work_o         (work_o),
    .upper_addr_o   (upper_addr_o),
    .pmem_rd_o      (pmem_rd_o),
    .pmem_addr_o    (pmem_addr_o),
    .pmem_data_i    (pmem_data_i)
);
